//--- bench/mrb_chk.sv
// Purpose: Protocol checks on the link between both ends.
// Assumes: One clock; reads answered one cycle after the command.
// Notes: Pattern values are handed in by the bench.
`timescale 1ns/1ps
module mrb_chk #(
  parameter logic [7:0] PAT_A = 8'hA5,
  parameter logic [7:0] PAT_B = 8'h3C
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Link signals
  input wire logic cmd_vld,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic rd_vld,
  input wire logic [7:0] rd_data,
  input wire logic rd_strobe
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  // Reads answered, answers only for reads
  a_read_gets_answer:
    assert property (cmd_vld && !cmd_wr |=> rd_vld)
    else $error("read command got no answer");
  a_no_stray_answer:
    assert property (rd_vld |-> $past(cmd_vld) && !$past(cmd_wr))
    else $error("answer without a read command");
  // Strobe toggles once per answer
  a_strobe_toggles:
    assert property (rd_vld |-> rd_strobe != $past(rd_strobe))
    else $error("strobe did not toggle on answer");
  a_strobe_quiet:
    assert property (!rd_vld |-> $stable(rd_strobe) && $stable(rd_data))
    else $error("strobe or data moved without answer");
  // Forbidden addresses never reach the device
  a_no_vendor_addr:
    assert property (cmd_vld |->
      !(cmd_addr inside {[8'h80:8'hBE], [8'hC0:8'hFE]}))
    else $error("vendor address sent on link");
  a_no_rsvd_write:
    assert property (cmd_vld && cmd_wr |-> cmd_addr != 8'h11)
    else $error("write to reserved register sent");
  // Info register unused bits read zero
  a_info_zero_bits:
    assert property (rd_vld && $past(cmd_addr) == 8'h00 |->
      rd_data[7:5] == 3'h0 && rd_data[2:1] == 2'h0)
    else $error("info register unused bits not zero");
  // Pattern registers
  a_pattern_a_data:
    assert property (rd_vld && $past(cmd_addr) == 8'h20 |-> rd_data == PAT_A)
    else $error("pattern A wrong");
  a_pattern_b_data:
    assert property (rd_vld && $past(cmd_addr) == 8'h28 |-> rd_data == PAT_B)
    else $error("pattern B wrong");
  // Main scenarios
  c_info_read: cover property (rd_vld && $past(cmd_addr) == 8'h00);
  c_cal_write: cover property (cmd_vld && cmd_wr && cmd_wdata == 8'hFF);
  c_pat_read: cover property (rd_vld && $past(cmd_addr) == 8'h28);
endmodule : mrb_chk

//--- bench/sdram_mode_register_map_tb.sv
// Purpose: Self-checking bench joining controller and device ends.
// Assumes: Inputs driven at the falling edge; auto-init timer shortened.
// Notes: Expected values follow the register map.
`timescale 1ns/1ps
module sdram_mode_register_map_tb;
  import mrb_pkg::*;
  localparam int unsigned AI_CYC = 20;
  localparam int unsigned ZQ_CYC = 20;
  localparam logic [7:0] PAT_A = 8'hA5;
  localparam logic [7:0] PAT_B = 8'h3C;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
  localparam logic [7:0] REV1 = 8'h01; // Arbitrary value
  localparam logic [7:0] REV2 = 8'h02; // Arbitrary value
  localparam logic [7:0] ORG = 8'h18;
  localparam logic [7:0] RFR_STAT = 8'h03;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_req = 1'b0;
  logic i_req_wr = 1'b0;
  logic [7:0] i_req_addr = 8'h00;
  logic [7:0] i_req_wdata = 8'h00;
  logic [7:0] i_rfu_mask = 8'h00;
  mrb_pad_t i_pad_state = MRB_PAD_OK;
  logic o_ready, o_rsp_vld, o_rejected, trim, cal_busy;
  logic [7:0] o_rsp_data, f1, f2, ioc, tm, bm;
  int err_total = 0;
  int tests_run = 0;
  int cmd_seen = 0;
  mrb_if lnk();

  // Clock and command counter
  always #25 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (lnk.cmd_vld === 1'b1) cmd_seen++;

  // Both ends and the checker
  mrb_ctrl_end u_mrb_ctrl_end (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_req(i_req), .i_req_wr(i_req_wr), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .i_rfu_mask(i_rfu_mask), .o_ready(o_ready),
    .o_rsp_vld(o_rsp_vld), .o_rsp_data(o_rsp_data),
    .o_rejected(o_rejected), .lnk(lnk));
  mrb_dev_end #(.AUTO_INIT_CYC(AI_CYC), .ZQINIT_CYC(ZQ_CYC),
    .MAKER_CODE(MAKER), .REV_CODE_1(REV1), .REV_CODE_2(REV2),
    .ORG_INFO(ORG), .REFRESH_STAT(RFR_STAT),
    .DQ_PAT_A(PAT_A), .DQ_PAT_B(PAT_B)) u_mrb_dev_end (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_pad_state(i_pad_state),
    .lnk(lnk), .o_feature_1(f1), .o_feature_2(f2), .o_io_config(ioc),
    .o_test_mode(tm), .o_bank_mask(bm), .o_factory_trim(trim),
    .o_cal_busy(cal_busy));
  mrb_chk #(.PAT_A(PAT_A), .PAT_B(PAT_B)) u_mrb_chk (.i_mclk(i_mclk),
    .i_srst(i_srst), .cmd_vld(lnk.cmd_vld), .cmd_wr(lnk.cmd_wr),
    .cmd_addr(lnk.cmd_addr), .cmd_wdata(lnk.cmd_wdata),
    .rd_vld(lnk.rd_vld), .rd_data(lnk.rd_data), .rd_strobe(lnk.rd_strobe));

  task automatic chk(input string nm, input logic [7:0] got,
    input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic do_reset();
    @(negedge i_mclk);
    i_srst = 1'b1;
    repeat (10) @(negedge i_mclk);
    i_srst = 1'b0;
  endtask : do_reset

  // One request; collects answer and refusal
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
    input logic [7:0] m, output logic [7:0] q, output logic rej);
    int n;
    n = 0;
    q = 8'hXX;
    rej = 1'b0;
    @(negedge i_mclk);
    while (o_ready !== 1'b1 && n < 50)
    begin
      @(negedge i_mclk);
      n++;
    end
    i_req = 1'b1;
    i_req_wr = wr;
    i_req_addr = a;
    i_req_wdata = d;
    i_rfu_mask = m;
    @(posedge i_mclk);
    repeat (6)
    begin
      @(negedge i_mclk);
      i_req = 1'b0;
      if (o_rsp_vld === 1'b1) q = o_rsp_data;
      if (o_rejected === 1'b1) rej = 1'b1;
    end
  endtask : xfer

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic r;
    xfer(1'b0, a, 8'h00, 8'h00, q, r);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [7:0] m);
    logic [7:0] q;
    logic r;
    xfer(1'b1, a, d, m, q, r);
  endtask : wr

  task automatic t_write_only();
    logic [7:0] adr [5] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h10};
    logic [7:0] outs [5];
    logic [7:0] q;
    logic s;
    for (int i = 0; i < 5; i++) wr(adr[i], 8'h40 + 8'(i), 8'h00);
    outs = '{f1, f2, ioc, tm, bm};
    for (int i = 0; i < 5; i++)
    begin
      chk("write-only value", outs[i], 8'h40 + 8'(i));
      s = lnk.rd_strobe;
      rd(adr[i], q);
      chk("strobe toggle", {7'h00, lnk.rd_strobe}, {7'h00, ~s});
    end
    wr(8'h01, 8'hFF, 8'h0F);
    chk("masked write", f1, 8'hF0);
  endtask : t_write_only

  task automatic t_read_only();
    logic [7:0] adr [4] = '{8'h04, 8'h06, 8'h07, 8'h08};
    logic [7:0] want [4] = '{RFR_STAT, REV1, REV2, ORG};
    logic [7:0] q;
    wr(8'h00, 8'hFF, 8'h00);
    wr(8'h20, 8'h00, 8'h00);
    chk("ro write no effect", f1, 8'hF0);
    chk("ro write no cal", {7'h00, cal_busy}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      rd(adr[i], q);
      chk("read-only value", q, want[i]);
    end
    chk("ready idle", {7'h00, o_ready}, 8'h01);
    rd(8'h00, q);
    chk("info after write", q, 8'h00);
    rd(8'h20, q);
    chk("pattern A", q, PAT_A);
    rd(8'h28, q);
    chk("pattern B", q, PAT_B);
    rd(8'h05, q);
    chk("maker code", q, MAKER);
  endtask : t_read_only

  task automatic t_refused();
    logic [7:0] adr [5] = '{8'h80, 8'hBE, 8'hC0, 8'hFE, 8'h11};
    logic [7:0] q;
    logic r;
    int n;
    for (int i = 0; i < 5; i++)
    begin
      n = cmd_seen;
      xfer(i == 4, adr[i], 8'h00, 8'h00, q, r);
      chk("refused", {7'h00, r}, 8'h01);
      chk("nothing sent", 8'(cmd_seen - n), 8'h00);
    end
    n = cmd_seen;
    wr(8'h0B, 8'hFF, 8'h00);
    chk("unmapped sent", 8'(cmd_seen - n), 8'h01);
    chk("unmapped no effect", f1, 8'hF0);
  endtask : t_refused

  task automatic t_auto_init();
    logic [7:0] q;
    wr(8'h3F, 8'h00, 8'h00);
    rd(8'h00, q);
    chk("init running", q, 8'h01);
    repeat (AI_CYC) @(negedge i_mclk);
    rd(8'h00, q);
    chk("init done in time", q, 8'h00);
  endtask : t_auto_init

  task automatic t_selftest();
    mrb_pad_t pads [3] = '{MRB_PAD_OK, MRB_PAD_SUPPLY, MRB_PAD_GND};
    logic [1:0] code [3] = '{2'h3, 2'h1, 2'h2};
    logic [7:0] q;
    for (int i = 0; i < 3; i++)
    begin
      do_reset();
      i_pad_state = pads[i];
      rd(8'h00, q);
      chk("not run", q, 8'h00);
      wr(8'h0A, 8'hFF, 8'h00);
      chk("cal busy", {7'h00, cal_busy}, 8'h01);
      rd(8'h00, q);
      chk("held while busy", q, 8'h00);
      repeat (ZQ_CYC) @(negedge i_mclk);
      rd(8'h00, q);
      chk("self-test code", q, {3'h0, code[i], 3'h0});
      chk("factory trim", {7'h00, trim}, 8'(i != 0));
      i_pad_state = MRB_PAD_OK;
      wr(8'h0A, 8'hFF, 8'h00);
      chk("cal again", {7'h00, cal_busy}, 8'(i == 0));
      repeat (ZQ_CYC) @(negedge i_mclk);
      rd(8'h00, q);
      chk("code kept", q, {3'h0, code[i], 3'h0});
    end
  endtask : t_selftest

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    do_reset();
    t_write_only();
    t_read_only();
    t_refused();
    t_auto_init();
    t_selftest();
    final_report();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    err_total++;
    $display("[ERR] watchdog expected done seen hang");
    final_report();
  end
endmodule : sdram_mode_register_map_tb

//--- core/mrb_ctrl_end.sv
// Purpose: Controller end: issues register reads and writes.
// Assumes: One request at a time; user waits for o_ready.
// Notes: Filters requests the device must never see.
`timescale 1ns/1ps
module mrb_ctrl_end
  import mrb_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // User side
  input wire logic i_req,
  input wire logic i_req_wr,
  input wire logic [7:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  input wire logic [7:0] i_rfu_mask,
  output logic o_ready,
  output logic o_rsp_vld,
  output logic [7:0] o_rsp_data,
  output logic o_rejected,
  // Link
  mrb_if.ctrl lnk
);
  import mrb_pkg::*;

  // Addresses the controller may never touch, or never write
  function automatic logic is_banned(input logic [7:0] a, input logic wr);
    logic vend;
    logic rsvd;
    vend = (a >= MRB_VEND0_LO && a <= MRB_VEND0_HI) ||
      (a >= MRB_VEND1_LO && a <= MRB_VEND1_HI);
    rsvd = (a == MRB_A_RESERVED_SEVENTEEN);
    return vend || (wr && rsvd);
  endfunction : is_banned

  logic vld_ff, nxt_vld;
  logic wr_ff, nxt_wr;
  logic [7:0] addr_ff, nxt_addr;
  logic [7:0] wd_ff, nxt_wd;
  logic busy_ff, nxt_busy;
  logic rsp_ff, nxt_rsp;
  logic [7:0] rdat_ff, nxt_rdat;
  logic rej_ff, nxt_rej;
  logic rdy_ff, nxt_rdy;

  // Request issue and answer capture
  always_comb
  begin
    nxt_vld = 1'b0;
    nxt_wr = wr_ff;
    nxt_addr = addr_ff;
    nxt_wd = wd_ff;
    nxt_busy = busy_ff;
    nxt_rsp = 1'b0;
    nxt_rdat = rdat_ff;
    nxt_rej = 1'b0;
    if (rdy_ff && i_req)
    begin
      if (is_banned(i_req_addr, i_req_wr))
        nxt_rej = 1'b1;
      else
      begin
        nxt_vld = 1'b1;
        nxt_wr = i_req_wr;
        nxt_addr = i_req_addr;
        nxt_wd = i_req_wdata & ~i_rfu_mask;
        nxt_busy = !i_req_wr;
      end
    end
    if (busy_ff && lnk.rd_vld)
    begin
      nxt_busy = 1'b0;
      nxt_rsp = 1'b1;
      nxt_rdat = lnk.rd_data;
    end
    // Ready once nothing is outstanding
    nxt_rdy = !nxt_busy && !nxt_vld;
  end

  // Registers
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      vld_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= MRB_ZERO8;
      wd_ff <= MRB_ZERO8;
      busy_ff <= 1'b0;
      rsp_ff <= 1'b0;
      rdat_ff <= MRB_ZERO8;
      rej_ff <= 1'b0;
      rdy_ff <= 1'b1;
    end
    else
    begin
      vld_ff <= nxt_vld;
      wr_ff <= nxt_wr;
      addr_ff <= nxt_addr;
      wd_ff <= nxt_wd;
      busy_ff <= nxt_busy;
      rsp_ff <= nxt_rsp;
      rdat_ff <= nxt_rdat;
      rej_ff <= nxt_rej;
      rdy_ff <= nxt_rdy;
    end
  end

  assign lnk.cmd_vld = vld_ff;
  assign lnk.cmd_wr = wr_ff;
  assign lnk.cmd_addr = addr_ff;
  assign lnk.cmd_wdata = wd_ff;
  assign o_ready = rdy_ff;
  assign o_rsp_vld = rsp_ff;
  assign o_rsp_data = rdat_ff;
  assign o_rejected = rej_ff;
endmodule : mrb_ctrl_end

//--- core/mrb_dev_end.sv
// Purpose: Device end: mode-register bank with info and self-test state.
// Assumes: Commands arrive from controller logic on the same clock.
// Notes: Answers every read one cycle after the command.
`timescale 1ns/1ps
module mrb_dev_end
  import mrb_pkg::*;
#(
  parameter int unsigned AUTO_INIT_CYC = MRB_AUTO_INIT_CYC,
  parameter int unsigned ZQINIT_CYC = MRB_ZQINIT_CYC,
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] REV_CODE_1 = 8'h01, // arbitrary value
  parameter logic [7:0] REV_CODE_2 = 8'h02, // arbitrary value
  parameter logic [7:0] ORG_INFO = 8'h00,
  parameter logic [7:0] REFRESH_STAT = 8'h03,
  parameter logic [7:0] DQ_PAT_A = 8'h00,
  parameter logic [7:0] DQ_PAT_B = 8'h00,
  parameter logic [7:0] UNDEF_DATA = 8'h00
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Pad condition from analog side
  input wire mrb_pkg::mrb_pad_t i_pad_state,
  // Link
  mrb_if.dev lnk,
  // Configuration and status outputs
  output logic [7:0] o_feature_1,
  output logic [7:0] o_feature_2,
  output logic [7:0] o_io_config,
  output logic [7:0] o_test_mode,
  output logic [7:0] o_bank_mask,
  output logic o_factory_trim,
  output logic o_cal_busy
);
  import mrb_pkg::*;

  // Access class of each address
  function automatic mrb_acc_t acc_of(input logic [7:0] a);
    unique case (a)
      MRB_A_DEVICE_INFO, MRB_A_REFRESH_RATE_STATUS, MRB_A_MAKER_CODE,
      MRB_A_REVISION_CODE_1, MRB_A_REVISION_CODE_2,
      MRB_A_ORGANIZATION_INFO, MRB_A_DQ_PATTERN_A,
      MRB_A_DQ_PATTERN_B: return MRB_ACC_RO;
      MRB_A_FEATURE_CTRL_1, MRB_A_FEATURE_CTRL_2, MRB_A_IO_CONFIG_1,
      MRB_A_TEST_MODE_CTRL, MRB_A_IO_CALIBRATION_CMD,
      MRB_A_BANK_REFRESH_MASK, MRB_A_SOFT_RESET_CMD: return MRB_ACC_WO;
      default: return MRB_ACC_NONE;
    endcase
  endfunction : acc_of

  // Pad state clocked in twice
  logic [1:0] pad_s1_ff, pad_s2_ff;
  logic [7:0] f1_ff, nxt_f1, f2_ff, nxt_f2, io_ff, nxt_io;
  logic [7:0] tm_ff, nxt_tm, bm_ff, nxt_bm;
  logic init_ff, nxt_init;
  logic [1:0] zq_ff, nxt_zq;
  logic trim_ff, nxt_trim;
  logic rv_ff, nxt_rv;
  logic [7:0] rd_ff, nxt_rd;
  logic stb_ff, nxt_stb;
  logic ld_init, ld_cal;
  logic init_busy, init_done, cal_busy, cal_done;
  logic wr_hit, rd_hit;
  mrb_acc_t acc;
  logic [7:0] info;

  assign acc = acc_of(lnk.cmd_addr);
  assign wr_hit = lnk.cmd_vld && lnk.cmd_wr && acc[1];
  assign rd_hit = lnk.cmd_vld && !lnk.cmd_wr;
  assign ld_init = wr_hit && lnk.cmd_addr == MRB_A_SOFT_RESET_CMD;
  // Faulty pad blocks further calibration
  assign ld_cal = wr_hit && lnk.cmd_addr == MRB_A_IO_CALIBRATION_CMD &&
    lnk.cmd_wdata == MRB_CAL_INIT && !cal_busy && !trim_ff;

  // Auto-init timer
  mrb_timer #(.CW(MRB_CW)) u_init_tmr (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_load(ld_init),
    .i_count(MRB_CW'(AUTO_INIT_CYC)),
    .o_busy(init_busy),
    .o_done(init_done)
  );

  // Calibration timer
  mrb_timer #(.CW(MRB_CW)) u_cal_tmr (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_load(ld_cal),
    .i_count(MRB_CW'(ZQINIT_CYC)),
    .o_busy(cal_busy),
    .o_done(cal_done)
  );

  // Device info word, unused bits zero
  always_comb
  begin
    info = MRB_ZERO8;
    info[MRB_BIT_AUTO_INIT] = init_ff;
    info[MRB_ZQ_LSB +: 2] = zq_ff;
  end

  // Register, status and read answer next values
  always_comb
  begin
    nxt_f1 = f1_ff;
    nxt_f2 = f2_ff;
    nxt_io = io_ff;
    nxt_tm = tm_ff;
    nxt_bm = bm_ff;
    nxt_init = init_ff;
    nxt_zq = zq_ff;
    nxt_rv = 1'b0;
    nxt_rd = rd_ff;
    nxt_stb = stb_ff;
    if (wr_hit)
    begin
      unique case (lnk.cmd_addr)
        MRB_A_FEATURE_CTRL_1: nxt_f1 = lnk.cmd_wdata;
        MRB_A_FEATURE_CTRL_2: nxt_f2 = lnk.cmd_wdata;
        MRB_A_IO_CONFIG_1: nxt_io = lnk.cmd_wdata;
        MRB_A_TEST_MODE_CTRL: nxt_tm = lnk.cmd_wdata;
        MRB_A_BANK_REFRESH_MASK: nxt_bm = lnk.cmd_wdata;
        default: nxt_f1 = f1_ff;
      endcase
    end
    if (ld_init)
      nxt_init = 1'b1;
    else if (init_done)
      nxt_init = 1'b0;
    if (cal_done)
    begin
      unique case (pad_s2_ff)
        MRB_PAD_SUPPLY: nxt_zq = MRB_ZQ_TO_SUPPLY;
        MRB_PAD_GND: nxt_zq = MRB_ZQ_TO_GND;
        default: nxt_zq = MRB_ZQ_PASS;
      endcase
    end
    // Factory trim follows a faulty pad result
    nxt_trim = nxt_zq == MRB_ZQ_TO_SUPPLY ||
      nxt_zq == MRB_ZQ_TO_GND;
    if (rd_hit)
    begin
      nxt_rv = 1'b1;
      nxt_stb = !stb_ff;
      unique case (lnk.cmd_addr)
        MRB_A_DEVICE_INFO: nxt_rd = info & MRB_INFO_USED;
        MRB_A_REFRESH_RATE_STATUS: nxt_rd = REFRESH_STAT;
        MRB_A_MAKER_CODE: nxt_rd = MAKER_CODE;
        MRB_A_REVISION_CODE_1: nxt_rd = REV_CODE_1;
        MRB_A_REVISION_CODE_2: nxt_rd = REV_CODE_2;
        MRB_A_ORGANIZATION_INFO: nxt_rd = ORG_INFO;
        MRB_A_DQ_PATTERN_A: nxt_rd = DQ_PAT_A;
        MRB_A_DQ_PATTERN_B: nxt_rd = DQ_PAT_B;
        default: nxt_rd = UNDEF_DATA;
      endcase
    end
  end

  // Registers
  always_ff @(posedge i_mclk)
  begin
    pad_s1_ff <= i_pad_state;
    pad_s2_ff <= pad_s1_ff;
    if (i_srst)
    begin
      f1_ff <= MRB_ZERO8;
      f2_ff <= MRB_ZERO8;
      io_ff <= MRB_ZERO8;
      tm_ff <= MRB_ZERO8;
      bm_ff <= MRB_ZERO8;
      init_ff <= 1'b0;
      zq_ff <= MRB_ZQ_NOT_RUN;
      trim_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= MRB_ZERO8;
      stb_ff <= 1'b0;
    end
    else
    begin
      f1_ff <= nxt_f1;
      f2_ff <= nxt_f2;
      io_ff <= nxt_io;
      tm_ff <= nxt_tm;
      bm_ff <= nxt_bm;
      init_ff <= nxt_init;
      zq_ff <= nxt_zq;
      trim_ff <= nxt_trim;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      stb_ff <= nxt_stb;
    end
  end

  // Outputs
  assign lnk.rd_vld = rv_ff;
  assign lnk.rd_data = rd_ff;
  assign lnk.rd_strobe = stb_ff;
  assign o_feature_1 = f1_ff;
  assign o_feature_2 = f2_ff;
  assign o_io_config = io_ff;
  assign o_test_mode = tm_ff;
  assign o_bank_mask = bm_ff;
  assign o_factory_trim = trim_ff;
  assign o_cal_busy = cal_busy;
endmodule : mrb_dev_end

//--- core/mrb_timer.sv
// Purpose: Down counter that flags the end of a timed operation.
// Assumes: Load and count on the same clock.
// Notes: o_done pulses one cycle when the count expires.
`timescale 1ns/1ps
module mrb_timer #(
  parameter int unsigned CW = 16
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Control
  input wire logic i_load,
  input wire logic [CW-1:0] i_count,
  // Status
  output logic o_busy,
  output logic o_done
);
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;

  // Next count
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (i_load)
    begin
      nxt_cnt = i_count;
      nxt_busy = 1'b1;
    end
    else if (busy_ff)
    begin
      if (cnt_ff <= CW'(1))
      begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end
      nxt_cnt = cnt_ff - CW'(1);
    end
  end

  // Registers
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign o_busy = busy_ff;
  assign o_done = done_ff;
endmodule : mrb_timer

//--- pkg/mrb_if.sv
// Purpose: Command link between controller and mode-register bank.
// Assumes: One clock; controller drives command, device drives answer.
// Notes: Read answer is a pulse with a strobe toggle.
`timescale 1ns/1ps
interface mrb_if;
  logic cmd_vld;
  logic cmd_wr;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic rd_vld;
  logic [7:0] rd_data;
  logic rd_strobe;
  modport ctrl (output cmd_vld, cmd_wr, cmd_addr, cmd_wdata,
    input rd_vld, rd_data, rd_strobe);
  modport dev (input cmd_vld, cmd_wr, cmd_addr, cmd_wdata,
    output rd_vld, rd_data, rd_strobe);
endinterface : mrb_if

//--- pkg/mrb_pkg.sv
// Purpose: Shared constants and types for the mode-register bank link.
// Assumes: One clock, 20 MHz; 8-bit register address and data.
// Notes: Offsets are the printed register addresses.
package mrb_pkg;
  localparam int unsigned MRB_AW = 8;
  localparam int unsigned MRB_DW = 8;
  // Register addresses
  localparam logic [7:0] MRB_A_DEVICE_INFO = 8'h00;
  localparam logic [7:0] MRB_A_FEATURE_CTRL_1 = 8'h01;
  localparam logic [7:0] MRB_A_FEATURE_CTRL_2 = 8'h02;
  localparam logic [7:0] MRB_A_IO_CONFIG_1 = 8'h03;
  localparam logic [7:0] MRB_A_REFRESH_RATE_STATUS = 8'h04;
  localparam logic [7:0] MRB_A_MAKER_CODE = 8'h05;
  localparam logic [7:0] MRB_A_REVISION_CODE_1 = 8'h06;
  localparam logic [7:0] MRB_A_REVISION_CODE_2 = 8'h07;
  localparam logic [7:0] MRB_A_ORGANIZATION_INFO = 8'h08;
  localparam logic [7:0] MRB_A_TEST_MODE_CTRL = 8'h09;
  localparam logic [7:0] MRB_A_IO_CALIBRATION_CMD = 8'h0A;
  localparam logic [7:0] MRB_A_BANK_REFRESH_MASK = 8'h10;
  localparam logic [7:0] MRB_A_RESERVED_SEVENTEEN = 8'h11;
  localparam logic [7:0] MRB_A_DQ_PATTERN_A = 8'h20;
  localparam logic [7:0] MRB_A_DQ_PATTERN_B = 8'h28;
  localparam logic [7:0] MRB_A_SOFT_RESET_CMD = 8'h3F;
  // Vendor ranges
  localparam logic [7:0] MRB_VEND0_LO = 8'h80;
  localparam logic [7:0] MRB_VEND0_HI = 8'hBE;
  localparam logic [7:0] MRB_VEND1_LO = 8'hC0;
  localparam logic [7:0] MRB_VEND1_HI = 8'hFE;
  // Device info fields
  localparam int unsigned MRB_BIT_AUTO_INIT = 0;
  localparam int unsigned MRB_BIT_DEV_TYPE = 1;
  localparam int unsigned MRB_BIT_DNV = 2;
  localparam int unsigned MRB_ZQ_LSB = 3;
  localparam logic [7:0] MRB_INFO_USED = 8'h1F;
  // Self-test codes
  localparam logic [1:0] MRB_ZQ_NOT_RUN = 2'h0;
  localparam logic [1:0] MRB_ZQ_TO_SUPPLY = 2'h1;
  localparam logic [1:0] MRB_ZQ_TO_GND = 2'h2;
  localparam logic [1:0] MRB_ZQ_PASS = 2'h3;
  // Calibration command code written to the calibration register
  localparam logic [7:0] MRB_CAL_INIT = 8'hFF;
  localparam logic [7:0] MRB_ZERO8 = 8'h00;
  // Timing
  localparam int unsigned MRB_CLK_MHZ = 20;
  localparam int unsigned MRB_T_AUTO_INIT_US = 10;
  localparam int unsigned MRB_AUTO_INIT_CYC = MRB_T_AUTO_INIT_US * MRB_CLK_MHZ;
  localparam int unsigned MRB_T_ZQINIT_US = 1;
  localparam int unsigned MRB_ZQINIT_CYC = MRB_T_ZQINIT_US * MRB_CLK_MHZ;
  localparam int unsigned MRB_CW = 16;
  // Access class
  typedef enum logic [1:0] {
    MRB_ACC_NONE = 2'b00,
    MRB_ACC_RO = 2'b01,
    MRB_ACC_WO = 2'b10,
    MRB_ACC_RW = 2'b11
  } mrb_acc_t;
  // Pad condition seen by self-test
  typedef enum logic [1:0] {
    MRB_PAD_OK = 2'b00,
    MRB_PAD_SUPPLY = 2'b01,
    MRB_PAD_GND = 2'b10
  } mrb_pad_t;
endpackage : mrb_pkg
